// ### verilog/sfir_top.sv
// serial flash event mask, raw status and clear logic with ahb-lite slave
//
// Operation
// - raw bit 11 mirrors tx fifo overflow
// - raw bit 10 mirrors tx fifo underflow
// - raw bit 9 mirrors rx fifo overflow
// - raw bit 8 mirrors rx fifo underflow
// - raw bit 7 mirrors tx fifo full
// - raw bit 6 tx fifo empty, resets 1
// - raw bit 5 mirrors rx fifo full
// - raw bit 4 rx fifo empty, resets 1
// - raw bit 3 tx room meets burst, resets 1
// - raw bit 2 rx data meets burst
// - raw bit 1 interface idle, resets 1
// - raw bit 0 transfer completed, resets 1
// - mask bit one blocks, zero passes
// - all mask bits reset to one
// - writing one to clear bit drops completion
// - writing zero to clear bit changes nothing
// - gated bit is raw and not masked
`timescale 1ns/1ps
module sfir_top
  import sfir_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  input  wire logic                  tx_fifo_overrun,
  input  wire logic                  tx_fifo_underrun,
  input  wire logic                  rx_fifo_overrun,
  input  wire logic                  rx_fifo_underrun,
  input  wire logic                  tx_fifo_full,
  input  wire logic                  tx_fifo_vacant,
  input  wire logic                  rx_fifo_full,
  input  wire logic                  rx_fifo_vacant,
  input  wire logic [SFIR_CNT_W-1:0] tx_free_count,
  input  wire logic [SFIR_CNT_W-1:0] rx_avail_count,
  input  wire logic                  xfer_idle,
  input  wire logic                  xfer_done,
  output logic [SFIR_BURST_SEL_W-1:0] tx_burst_sel,
  output logic [SFIR_BURST_SEL_W-1:0] rx_burst_sel,
  output logic [SFIR_NUM_EVENTS-1:0]  raw_flags,
  output logic                       irq
);

  // bus data phase state
  logic                        wr_pend_q;
  logic [7:0]                  wr_ofs_q;
  logic [31:0]                 rdata_q;
  logic [31:0]                 rdata_d;
  logic                        addr_take;

  // register state
  logic [SFIR_NUM_EVENTS-1:0]  mask_q;
  logic [SFIR_NUM_EVENTS-1:0]  raw_q;
  logic [SFIR_NUM_EVENTS-1:0]  raw_d;
  logic [SFIR_NUM_EVENTS-1:0]  gated;
  logic [SFIR_BURST_SEL_W-1:0] tx_burst_q;
  logic [SFIR_BURST_SEL_W-1:0] rx_burst_q;
  logic                        irq_q;
  logic                        completion_q;
  logic                        completion_d;
  logic                        completion_ack;
  logic                        tx_burst_hit;
  logic                        rx_burst_hit;

  // write strobes decoded in the data phase
  logic                        wr_mask;
  logic                        wr_burst;
  logic                        wr_clear;

  // address phase is taken on a selected nonseq word transfer
  assign addr_take = hsel && hready && (htrans == SFIR_HTRANS_NONSEQ) && (hsize == SFIR_HSIZE_WORD);

  assign wr_mask  = wr_pend_q && (wr_ofs_q == SFIR_MASK_OFS);
  assign wr_burst = wr_pend_q && (wr_ofs_q == SFIR_BURST_CFG_OFS);
  assign wr_clear = wr_pend_q && (wr_ofs_q == SFIR_CLEAR_OFS);

  // only bit 0 of the clear register acts; upper bits are ignored
  assign completion_ack = wr_clear && hwdata[SFIR_COMPLETION_ACK_BIT];

  // capture write address for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
    end else begin
      wr_pend_q <= addr_take && hwrite;
      wr_ofs_q  <= addr_take ? haddr[7:0] : wr_ofs_q;
    end
  end

  // threshold compares against the burst settings
  sfir_burst_cmp u_tx_burst (
    .burst_sel (tx_burst_q),
    .level     (tx_free_count),
    .reached   (tx_burst_hit)
  );

  sfir_burst_cmp u_rx_burst (
    .burst_sel (rx_burst_q),
    .level     (rx_avail_count),
    .reached   (rx_burst_hit)
  );

  // completion flag: a new completion wins over a same-cycle clear
  always_comb begin
    completion_d = completion_q;
    if (completion_ack) begin
      completion_d = 1'b0;
    end
    if (xfer_done) begin
      completion_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      completion_q <= 1'b1;
    end else begin
      completion_q <= completion_d;
    end
  end

  // next raw flags from live conditions
  always_comb begin
    raw_d                       = '0;
    raw_d[SFIR_TX_OVERRUN_BIT]  = tx_fifo_overrun;
    raw_d[SFIR_TX_UNDERRUN_BIT] = tx_fifo_underrun;
    raw_d[SFIR_RX_OVERRUN_BIT]  = rx_fifo_overrun;
    raw_d[SFIR_RX_UNDERRUN_BIT] = rx_fifo_underrun;
    raw_d[SFIR_TX_FULL_BIT]     = tx_fifo_full;
    raw_d[SFIR_TX_VACANT_BIT]   = tx_fifo_vacant;
    raw_d[SFIR_RX_FULL_BIT]     = rx_fifo_full;
    raw_d[SFIR_RX_VACANT_BIT]   = rx_fifo_vacant;
    raw_d[SFIR_TX_BURST_BIT]    = tx_burst_hit;
    raw_d[SFIR_RX_BURST_BIT]    = rx_burst_hit;
    raw_d[SFIR_IDLE_BIT]        = xfer_idle;
    raw_d[SFIR_COMPLETION_BIT]  = completion_d;
  end

  // raw flags register, reset to the documented pattern
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_q <= SFIR_RAW_RST;
    end else begin
      raw_q <= raw_d;
    end
  end

  // mask register, all sources start blocked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= SFIR_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= hwdata[SFIR_NUM_EVENTS-1:0];
    end
  end

  // burst settings register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_burst_q <= SFIR_BURST_SEL_RST;
      rx_burst_q <= SFIR_BURST_SEL_RST;
    end else if (wr_burst) begin
      tx_burst_q <= hwdata[SFIR_TX_BURST_LSB +: SFIR_BURST_SEL_W];
      rx_burst_q <= hwdata[SFIR_RX_BURST_LSB +: SFIR_BURST_SEL_W];
    end
  end

  // gated flags, one per event
  genvar gi;
  generate
    for (gi = 0; gi < SFIR_NUM_EVENTS; gi++) begin : g_gate
      assign gated[gi] = raw_q[gi] && !mask_q[gi];
    end
  endgenerate

  // single interrupt line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |gated;
    end
  end

  // read mux, evaluated at the address phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (haddr[7:0])
      SFIR_MASK_OFS:  rdata_d[SFIR_NUM_EVENTS-1:0] = mask_q;
      SFIR_RAW_OFS:   rdata_d[SFIR_NUM_EVENTS-1:0] = raw_q;
      SFIR_GATED_OFS: rdata_d[SFIR_NUM_EVENTS-1:0] = gated;
      SFIR_BURST_CFG_OFS: begin
        rdata_d[SFIR_TX_BURST_LSB +: SFIR_BURST_SEL_W] = tx_burst_q;
        rdata_d[SFIR_RX_BURST_LSB +: SFIR_BURST_SEL_W] = rx_burst_q;
      end
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  // read data held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = rdata_q;
  assign tx_burst_sel = tx_burst_q;
  assign rx_burst_sel = rx_burst_q;
  assign raw_flags    = raw_q;
  assign irq          = irq_q;

endmodule : sfir_top

// ### verilog/sfir_pkg.sv
// shared constants for the serial flash event mask, raw status and clear block
package sfir_pkg;

  // register byte offsets
  localparam logic [7:0] SFIR_BURST_CFG_OFS  = 8'h28;
  localparam logic [7:0] SFIR_GATED_OFS      = 8'h2c;
  localparam logic [7:0] SFIR_MASK_OFS       = 8'h30;
  localparam logic [7:0] SFIR_RAW_OFS        = 8'h34;
  localparam logic [7:0] SFIR_CLEAR_OFS      = 8'h38;

  // event bit positions
  localparam int SFIR_NUM_EVENTS             = 12;
  localparam int SFIR_TX_OVERRUN_BIT         = 11;
  localparam int SFIR_TX_UNDERRUN_BIT        = 10;
  localparam int SFIR_RX_OVERRUN_BIT         = 9;
  localparam int SFIR_RX_UNDERRUN_BIT        = 8;
  localparam int SFIR_TX_FULL_BIT            = 7;
  localparam int SFIR_TX_VACANT_BIT          = 6;
  localparam int SFIR_RX_FULL_BIT            = 5;
  localparam int SFIR_RX_VACANT_BIT          = 4;
  localparam int SFIR_TX_BURST_BIT           = 3;
  localparam int SFIR_RX_BURST_BIT           = 2;
  localparam int SFIR_IDLE_BIT               = 1;
  localparam int SFIR_COMPLETION_BIT         = 0;

  // burst configuration fields
  localparam int SFIR_TX_BURST_LSB           = 12;
  localparam int SFIR_RX_BURST_LSB           = 8;
  localparam int SFIR_BURST_SEL_W            = 2;

  // clear register field
  localparam int SFIR_COMPLETION_ACK_BIT     = 0;

  // fifo geometry: eight entries, counts 0..8
  localparam int SFIR_CNT_W                  = 4;

  // burst setting code to entry count
  localparam logic [3:0] SFIR_BURST_CODE0    = 4'h1;
  localparam logic [3:0] SFIR_BURST_CODE1    = 4'h4;
  localparam logic [3:0] SFIR_BURST_CODE2    = 4'h8;
  localparam logic [3:0] SFIR_BURST_CODE3    = 4'h8;

  // values after reset
  localparam logic [11:0] SFIR_RAW_RST       = 12'h05b;
  localparam logic [11:0] SFIR_MASK_RST      = 12'hfff;
  localparam logic [1:0]  SFIR_BURST_SEL_RST = 2'h0;

  // ahb-lite encodings
  localparam logic [1:0] SFIR_HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0] SFIR_HSIZE_WORD     = 3'h2;

endpackage : sfir_pkg

// ### verilog/sfir_burst_cmp.sv
// burst threshold compare for one fifo side
`timescale 1ns/1ps
module sfir_burst_cmp
  import sfir_pkg::*;
(
  input  wire logic [SFIR_BURST_SEL_W-1:0] burst_sel,
  input  wire logic [SFIR_CNT_W-1:0]       level,
  output logic                             reached
);

  logic [SFIR_CNT_W-1:0] burst_words;

  // decode the burst setting into a word count
  always_comb begin
    unique case (burst_sel)
      2'h0: burst_words = SFIR_BURST_CODE0;
      2'h1: burst_words = SFIR_BURST_CODE1;
      2'h2: burst_words = SFIR_BURST_CODE2;
      2'h3: burst_words = SFIR_BURST_CODE3;
    endcase
  end

  // at least one burst of room or data
  assign reached = (level >= burst_words);

endmodule : sfir_burst_cmp

// ### test/sfir_assertions.sv
// concurrent checks on the event block ports
`timescale 1ns/1ps
module sfir_checker
  import sfir_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        tx_fifo_overrun,
  input wire logic        tx_fifo_underrun,
  input wire logic        tx_fifo_full,
  input wire logic        tx_fifo_vacant,
  input wire logic        xfer_idle,
  input wire logic        xfer_done,
  input wire logic [11:0] raw_flags,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire         wr_a = hsel && htrans == SFIR_HTRANS_NONSEQ && hwrite;
  logic [11:0] mask_q;
  logic        mwr_q, cwr_q;
  // shadow of the mask, loaded where the data phase ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= SFIR_MASK_RST;
      mwr_q  <= 1'b0;
      cwr_q  <= 1'b0;
    end else begin
      mask_q <= mwr_q ? hwdata[11:0] : mask_q;
      mwr_q  <= wr_a && haddr[7:0] == SFIR_MASK_OFS;
      cwr_q  <= wr_a && haddr[7:0] == SFIR_CLEAR_OFS;
    end
  end
  sequence s_clr_one;
    wr_a && haddr[7:0] == SFIR_CLEAR_OFS ##1 hwdata[SFIR_COMPLETION_ACK_BIT] && !xfer_done;
  endsequence
  chk_reset_raw: assert property ($rose(hresetn) |-> raw_flags == SFIR_RAW_RST && !irq)
    else $error("bad reset flags");
  chk_tx_errors: assert property ($past(hresetn) |-> raw_flags[11:10] == $past({tx_fifo_overrun, tx_fifo_underrun}))
    else $error("bad tx errors");
  chk_tx_levels: assert property ($past(hresetn) |-> raw_flags[7:6] == $past({tx_fifo_full, tx_fifo_vacant}))
    else $error("bad tx levels");
  chk_idle_flag: assert property ($past(hresetn) |-> raw_flags[1] == $past(xfer_idle))
    else $error("bad idle flag");
  chk_done_set: assert property (xfer_done |=> raw_flags[0])
    else $error("done not set");
  chk_done_clear: assert property (s_clr_one |=> !raw_flags[0])
    else $error("done not cleared");
  chk_done_sticky: assert property (raw_flags[0] && !(cwr_q && hwdata[0]) |=> raw_flags[0])
    else $error("done dropped");
  chk_irq_gate: assert property ($past(hresetn) |-> irq == |($past(raw_flags) & ~$past(mask_q)))
    else $error("bad irq");
endmodule : sfir_checker
bind sfir_top sfir_checker i_sfir_checker (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .tx_fifo_overrun, .tx_fifo_underrun, .tx_fifo_full, .tx_fifo_vacant, .xfer_idle, .xfer_done, .raw_flags, .irq);

// ### test/tb_top.sv
// self-checking bench for the event block
`timescale 1ns/1ps
module tb_top
  import sfir_pkg::*;
;
  logic        hclk, hresetn, hwrite, hreadyout, irq, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [11:0] ev, raw_flags;
  logic [3:0]  txc, rxc;
  logic [1:0]  htrans, tx_sel, rx_sel;
  int          num_errors, total_checks;
  sfir_top i_sfir_top (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(SFIR_HSIZE_WORD), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .tx_fifo_overrun(ev[11]), .tx_fifo_underrun(ev[10]),
    .rx_fifo_overrun(ev[9]), .rx_fifo_underrun(ev[8]), .tx_fifo_full(ev[7]), .tx_fifo_vacant(ev[6]),
    .rx_fifo_full(ev[5]), .rx_fifo_vacant(ev[4]), .tx_free_count(txc), .rx_avail_count(rxc), .xfer_idle(ev[1]),
    .xfer_done(ev[0]), .tx_burst_sel(tx_sel), .rx_burst_sel(rx_sel), .raw_flags, .irq);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic wait_rdy;
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 20) begin
      num_errors++;
      final_report();
    end
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= SFIR_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : bus
  task automatic setev(input logic [11:0] v);
    ev <= v;
    repeat (2) @(posedge hclk);
  endtask : setev
  task automatic t_mirror;
    for (int i = 1; i < 12; i++) begin
      if (i == 2 || i == 3) continue;
      setev(12'h1 << i);
      bus(1'b0, SFIR_RAW_OFS, 32'h0);
      check(rd, {20'h0, (12'h1 << i) | 12'h009});
    end
  endtask : t_mirror
  task automatic t_burst;
    logic [3:0] th [4] = '{SFIR_BURST_CODE0, SFIR_BURST_CODE1, SFIR_BURST_CODE2, SFIR_BURST_CODE3};
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, SFIR_BURST_CFG_OFS, {18'h0, 2'(c), 2'h0, 2'(c), 8'h0});
      bus(1'b0, SFIR_BURST_CFG_OFS, 32'h0);
      check(rd, {18'h0, 2'(c), 2'h0, 2'(c), 8'h0});
      check({tx_sel, rx_sel}, {2'(c), 2'(c)});
      for (int s = 0; s < 2; s++) begin
        txc <= th[c] - 4'(s ^ 1);
        rxc <= th[c] - 4'(s);
        setev(12'h052);
        bus(1'b0, SFIR_RAW_OFS, 32'h0);
        check(rd, s ? 32'h05b : 32'h057);
      end
    end
  endtask : t_burst
  task automatic t_done;
    bus(1'b1, SFIR_CLEAR_OFS, 32'h0);
    bus(1'b0, SFIR_RAW_OFS, 32'h0);
    check(rd, 32'h05b);
    bus(1'b1, SFIR_CLEAR_OFS, 32'h1);
    bus(1'b0, SFIR_RAW_OFS, 32'h0);
    check(rd, 32'h05a);
    ev <= 12'h053;
    @(posedge hclk);
    setev(12'h052);
    bus(1'b0, SFIR_RAW_OFS, 32'h0);
    check(rd, 32'h05b);
  endtask : t_done
  task automatic t_irq;
    bus(1'b0, SFIR_MASK_OFS, 32'h0);
    check(rd, {20'h0, SFIR_MASK_RST});
    check(irq, 1'b0);
    bus(1'b1, SFIR_MASK_OFS, 32'hffe);
    repeat (2) @(posedge hclk);
    check(irq, 1'b1);
    bus(1'b0, SFIR_GATED_OFS, 32'h0);
    check(rd, 32'h001);
    bus(1'b1, SFIR_CLEAR_OFS, 32'h1);
    repeat (2) @(posedge hclk);
    check(irq, 1'b0);
    bus(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0);
  endtask : t_irq
  initial begin
    {hresetn, hwrite} = 2'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    ev = 12'h052;
    txc = 4'h8;
    rxc = 4'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge hclk);
    check(raw_flags, SFIR_RAW_RST);
    hresetn <= 1'b1;
    t_mirror();
    t_burst();
    t_done();
    t_irq();
    final_report();
  end
endmodule : tb_top
